// *** rtl/dpr_ram.sv ***
// Purpose: True dual-port RAM over one 4096-bit array with collision model.
// Assumes: Both ports sample on clk; window counted in clk edges.
// Notes:   Invalid data is modelled as unknown values in array or read bus.
`timescale 1ns/1ps

// Overview of operation
// - Collisions only count for overlapping cells with at least one write.
// - Two writes to one cell inside the window leave that cell unknown.
// - Write against read inside the window: write stored, reader gets unknown.
// - A writing port shows its own write data on its read bus unless its output reset is high.
// - A read bus holds its value when the other port later writes.
// - A new read after the other port's write returns the new value once the window has passed.
// - Reads outside the window after a write return the written data.
// - Disabled port neither writes nor changes its read bus.
// - Enabled with write enable stores input; otherwise reads to output.
// - Port output reset clears its read bus synchronously while the port is enabled, memory untouched.
// - One 4096-bit array; each port 1,2,4,8 or 16 bits wide.
module dpr_ram
   import dpr_pkg::*;
#(
   parameter int unsigned A_WIDTH = DPR_DEF_WIDTH,
   parameter int unsigned B_WIDTH = DPR_DEF_WIDTH,
   parameter int unsigned CCS_WINDOW_CYC = DPR_CCS_WINDOW_CYC,
   localparam int unsigned A_ADDR_W = $clog2(DPR_ARRAY_BITS / A_WIDTH),
   localparam int unsigned B_ADDR_W = $clog2(DPR_ARRAY_BITS / B_WIDTH)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic port_a_en,
   input wire logic port_a_we,
   input wire logic port_a_out_rst,
   input wire logic [A_ADDR_W-1:0] port_a_addr,
   input wire logic [A_WIDTH-1:0] port_a_write_data_in,
   output logic [A_WIDTH-1:0] port_a_read_bus,
   input wire logic port_b_en,
   input wire logic port_b_we,
   input wire logic port_b_out_rst,
   input wire logic [B_ADDR_W-1:0] port_b_addr,
   input wire logic [B_WIDTH-1:0] port_b_write_data_in,
   output logic [B_WIDTH-1:0] port_b_read_bus
);

   // ==========================================================
   // Elaboration checks
   if (!dpr_width_ok(A_WIDTH) || !dpr_width_ok(B_WIDTH)) begin : g_bad_width
      $error("port width must be 1, 2, 4, 8 or 16");
   end
   if (CCS_WINDOW_CYC < 1 || CCS_WINDOW_CYC > 255) begin : g_bad_window
      $error("collision window must be 1 to 255 edges");
   end

   // ==========================================================
   // Storage and decode
   logic [DPR_ARRAY_BITS-1:0] mem_q;
   logic [DPR_BIT_IDX_W-1:0] a_base;
   logic [DPR_BIT_IDX_W-1:0] b_base;
   logic a_wr;
   logic a_rd;
   logic b_wr;
   logic b_rd;
   logic same_edge_ovl;
   logic a_last_wr_ovl;
   logic b_last_wr_ovl;
   logic a_recent;
   logic b_recent;
   logic [DPR_BIT_IDX_W-1:0] a_last_base;
   logic [DPR_BIT_IDX_W-1:0] b_last_base;
   logic a_wr_bad;
   logic b_wr_bad;
   logic a_rd_bad;
   logic b_rd_bad;
   logic [A_WIDTH-1:0] a_read_d;
   logic [B_WIDTH-1:0] b_read_d;

   // First array bit of a word
   function automatic logic [DPR_BIT_IDX_W-1:0] word_base(
      input int unsigned addr,
      input int unsigned width
   );
      word_base = DPR_BIT_IDX_W'(addr * width);
   endfunction : word_base

   // Access meeting the other port's write now or inside the window
   function automatic logic hits_write(
      input logic access,
      input logic other_wr_now,
      input logic same_ovl,
      input logic past_ovl
   );
      hits_write = access && ((other_wr_now && same_ovl) || past_ovl);
   endfunction : hits_write

   // Bit address of the first cell of each word
   assign a_base = word_base(32'(port_a_addr), A_WIDTH);
   assign b_base = word_base(32'(port_b_addr), B_WIDTH);

   assign a_wr = port_a_en && port_a_we;
   assign a_rd = port_a_en && !port_a_we;
   assign b_wr = port_b_en && port_b_we;
   assign b_rd = port_b_en && !port_b_we;

   // ==========================================================
   // Collision detection
   assign same_edge_ovl = dpr_overlap(a_base, A_WIDTH, b_base, B_WIDTH);
   // Other port's earlier write still inside the window
   assign a_last_wr_ovl = b_recent && dpr_overlap(a_base, A_WIDTH, b_last_base, B_WIDTH);
   assign b_last_wr_ovl = a_recent && dpr_overlap(b_base, B_WIDTH, a_last_base, A_WIDTH);

   assign a_wr_bad = hits_write(a_wr, b_wr, same_edge_ovl, a_last_wr_ovl);
   assign b_wr_bad = hits_write(b_wr, a_wr, same_edge_ovl, b_last_wr_ovl);
   assign a_rd_bad = hits_write(a_rd, b_wr, same_edge_ovl, a_last_wr_ovl);
   assign b_rd_bad = hits_write(b_rd, a_wr, same_edge_ovl, b_last_wr_ovl);

   dpr_wr_tracker #(
      .WINDOW_CYC(CCS_WINDOW_CYC)
   ) u_a_track (
      .clk(clk),
      .rst_n(rst_n),
      .wr_now(a_wr),
      .wr_base(a_base),
      .last_base(a_last_base),
      .recent(a_recent)
   );

   dpr_wr_tracker #(
      .WINDOW_CYC(CCS_WINDOW_CYC)
   ) u_b_track (
      .clk(clk),
      .rst_n(rst_n),
      .wr_now(b_wr),
      .wr_base(b_base),
      .last_base(b_last_base),
      .recent(b_recent)
   );

   // ==========================================================
   // Array writes; output reset never touches the array
   always_ff @(posedge clk) begin
      if (a_wr) begin
         mem_q[a_base +: A_WIDTH] <= a_wr_bad ? {A_WIDTH{1'bx}} : port_a_write_data_in;
      end
      if (b_wr) begin
         mem_q[b_base +: B_WIDTH] <= b_wr_bad ? {B_WIDTH{1'bx}} : port_b_write_data_in;
      end
      // Both writing overlapped cells on one edge: overlap goes unknown
      if (a_wr && b_wr && same_edge_ovl) begin
         for (int i = 0; i < int'(A_WIDTH); i++) begin
            if (dpr_overlap(DPR_BIT_IDX_W'(32'(a_base) + i), 1, b_base, B_WIDTH)) begin
               mem_q[32'(a_base) + i] <= 1'bx;
            end
         end
      end
   end

   // ==========================================================
   // Read bus next values
   always_comb begin
      a_read_d = port_a_read_bus;
      if (port_a_en) begin
         if (port_a_out_rst) begin
            a_read_d = '0;
         end else if (port_a_we) begin
            a_read_d = port_a_write_data_in;
         end else if (a_rd_bad) begin
            a_read_d = {A_WIDTH{1'bx}};
         end else begin
            a_read_d = mem_q[a_base +: A_WIDTH];
         end
      end
   end

   always_comb begin
      b_read_d = port_b_read_bus;
      if (port_b_en) begin
         if (port_b_out_rst) begin
            b_read_d = '0;
         end else if (port_b_we) begin
            b_read_d = port_b_write_data_in;
         end else if (b_rd_bad) begin
            b_read_d = {B_WIDTH{1'bx}};
         end else begin
            b_read_d = mem_q[b_base +: B_WIDTH];
         end
      end
   end

   // ==========================================================
   // Read bus registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         port_a_read_bus <= '0;
      end else begin
         port_a_read_bus <= a_read_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         port_b_read_bus <= '0;
      end else begin
         port_b_read_bus <= b_read_d;
      end
   end

endmodule : dpr_ram

// *** include/dpr_pkg.sv ***
// Purpose: Shared constants for the dual-port shared-array RAM.
// Assumes: One system clock at 40 MHz for both ports.
// Notes:   Collision window is given in ns and turned into clock edges.
package dpr_pkg;

   // ==========================================================
   // Array geometry
   localparam int unsigned DPR_ARRAY_BITS = 4096;
   localparam int unsigned DPR_BIT_IDX_W = 12;
   localparam int unsigned DPR_MAX_WIDTH = 16;
   localparam int unsigned DPR_DEF_WIDTH = 16;

   // ==========================================================
   // Timing
   localparam int unsigned DPR_CLK_PERIOD_NS = 25;
   localparam int unsigned DPR_CCS_WINDOW_NS = 25;
   // Least time: round up, never below one edge
   localparam int unsigned DPR_CCS_WINDOW_CYC_RAW =
      (DPR_CCS_WINDOW_NS + DPR_CLK_PERIOD_NS - 1) / DPR_CLK_PERIOD_NS;
   localparam int unsigned DPR_CCS_WINDOW_CYC =
      (DPR_CCS_WINDOW_CYC_RAW < 1) ? 1 : DPR_CCS_WINDOW_CYC_RAW;
   localparam int unsigned DPR_AGE_W = 8;
   localparam logic [DPR_AGE_W-1:0] DPR_AGE_MAX = 8'hFF;

   // ==========================================================
   // Reset values
   localparam logic [DPR_BIT_IDX_W-1:0] DPR_BASE_RST = 12'h000;
   localparam logic [DPR_AGE_W-1:0] DPR_AGE_RST = 8'hFF;

   // True when two bit ranges of the shared array overlap
   function automatic logic dpr_overlap(
      input logic [DPR_BIT_IDX_W-1:0] base_x,
      input int unsigned width_x,
      input logic [DPR_BIT_IDX_W-1:0] base_y,
      input int unsigned width_y
   );
      int unsigned bx;
      int unsigned by;
      bx = int'(base_x);
      by = int'(base_y);
      dpr_overlap = (bx < by + width_y) && (by < bx + width_x);
   endfunction : dpr_overlap

   function automatic logic dpr_width_ok(input int unsigned w);
      dpr_width_ok = (w == 1) || (w == 2) || (w == 4) || (w == 8) || (w == 16);
   endfunction : dpr_width_ok

endpackage : dpr_pkg

// *** rtl/dpr_wr_tracker.sv ***
// Purpose: Remembers one port's last write and how many edges ago it was.
// Assumes: Synchronous inputs on clk.
// Notes:   recent is high while that write is still inside the window.
`timescale 1ns/1ps
module dpr_wr_tracker
   import dpr_pkg::*;
#(
   parameter int unsigned WINDOW_CYC = DPR_CCS_WINDOW_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_now,
   input wire logic [DPR_BIT_IDX_W-1:0] wr_base,
   output logic [DPR_BIT_IDX_W-1:0] last_base,
   output logic recent
);

   logic [DPR_AGE_W-1:0] age_q;
   logic [DPR_BIT_IDX_W-1:0] base_q;

   // ==========================================================
   // Elaboration check: the age counter saturates at its maximum
   if (WINDOW_CYC < 1 || WINDOW_CYC > 32'(DPR_AGE_MAX)) begin : g_bad_window
      $error("tracker window must be 1 to 255 edges");
   end

   // ==========================================================
   // Age counter, saturating
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         age_q <= DPR_AGE_RST;
      end else if (wr_now) begin
         age_q <= '0;
      end else if (age_q != DPR_AGE_MAX) begin
         age_q <= age_q + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         base_q <= DPR_BASE_RST;
      end else if (wr_now) begin
         base_q <= wr_base;
      end
   end

   // age 0 means one edge has passed since the write
   assign recent = (WINDOW_CYC > 1) && (32'(age_q) + 32'd1 < 32'(WINDOW_CYC));
   assign last_base = base_q;

endmodule : dpr_wr_tracker

// *** verification/dpr_ram_sva.sv ***
// Purpose: Port-level checks for dpr_ram.
// Assumes: Equal port widths, window of at most two edges.
// Notes: Bound from the bench top.
`timescale 1ns/1ps
module dpr_ram_sva
   import dpr_pkg::*;
#(
   parameter int unsigned A_WIDTH = 16,
   parameter int unsigned B_WIDTH = 16,
   parameter int unsigned CCS_WINDOW_CYC = 2,
   localparam int unsigned AW = $clog2(DPR_ARRAY_BITS / A_WIDTH),
   localparam int unsigned BW = $clog2(DPR_ARRAY_BITS / B_WIDTH)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic port_a_en,
   input wire logic port_a_we,
   input wire logic port_a_out_rst,
   input wire logic [AW-1:0] port_a_addr,
   input wire logic [A_WIDTH-1:0] port_a_write_data_in,
   input wire logic [A_WIDTH-1:0] port_a_read_bus,
   input wire logic port_b_en,
   input wire logic port_b_we,
   input wire logic port_b_out_rst,
   input wire logic [BW-1:0] port_b_addr,
   input wire logic [B_WIDTH-1:0] port_b_write_data_in,
   input wire logic [B_WIDTH-1:0] port_b_read_bus
);
   // ===
   // Helpers and sequences
   logic a_wr;
   logic a_any;
   logic b_wr;
   assign a_wr = port_a_en && port_a_we && !port_a_out_rst;
   assign a_any = port_a_en && port_a_we;
   assign b_wr = port_b_en && port_b_we;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_a_wr_quiet;
      !b_wr ##1 a_wr && !b_wr;
   endsequence
   // ===
   // Properties
   property p_a_echo;
      a_wr |=> port_a_read_bus == $past(port_a_write_data_in);
   endproperty
   a_a_echo: assert property (p_a_echo) else $error("port A bus misses write data");
   property p_b_echo;
      port_b_en && port_b_we && !port_b_out_rst |=> port_b_read_bus == $past(port_b_write_data_in);
   endproperty
   a_b_echo: assert property (p_b_echo) else $error("port B bus misses write data");
   property p_a_idle;
      !port_a_en |=> $stable(port_a_read_bus);
   endproperty
   a_a_idle: assert property (p_a_idle) else $error("port A bus moved while off");
   property p_b_idle;
      !port_b_en |=> $stable(port_b_read_bus);
   endproperty
   a_b_idle: assert property (p_b_idle) else $error("port B bus moved while off");
   property p_a_clr;
      port_a_en && port_a_out_rst |=> port_a_read_bus == '0;
   endproperty
   a_a_clr: assert property (p_a_clr) else $error("port A bus not cleared");
   property p_b_clr;
      port_b_en && port_b_out_rst |=> port_b_read_bus == '0;
   endproperty
   a_b_clr: assert property (p_b_clr) else $error("port B bus not cleared");
   property p_a_own;
      s_a_wr_quiet ##1 port_a_en && !port_a_we && !port_a_out_rst && !b_wr
         && port_a_addr == $past(port_a_addr) |=> port_a_read_bus == $past(port_a_write_data_in, 2);
   endproperty
   a_a_own: assert property (p_a_own) else $error("port A read misses own write");
   property p_b_sees;
      s_a_wr_quiet ##1 !a_any && !b_wr ##1 port_b_en && !port_b_we && !port_b_out_rst && !a_any
         && port_b_addr == $past(port_a_addr, 2) |=> port_b_read_bus == $past(port_a_write_data_in, 3);
   endproperty
   a_b_sees: assert property (p_b_sees) else $error("port B read misses port A write");
endmodule : dpr_ram_sva

// *** verification/dpr_port_drv.sv ***
// Purpose: User logic model driving one port of dpr_ram.
// Assumes: Called just after a rising edge.
// Notes: An idle port shows changing address and data.
`timescale 1ns/1ps
module dpr_port_drv #(
   parameter int unsigned W = 16,
   parameter int unsigned AW = 8
) (
   output logic en,
   output logic we,
   output logic out_rst,
   output logic [AW-1:0] addr,
   output logic [W-1:0] din
);
   initial begin
      en = 1'b0;
      we = 1'b0;
      out_rst = 1'b0;
      addr = '0;
      din = '0;
   end
   // Same address on both ports only where a collision is meant
   task automatic put(input logic [2:0] c, input logic [AW-1:0] a, input logic [W-1:0] d);
      {en, we, out_rst} = c;
      addr = c[2] ? a : ~addr;
      din = c[2] ? d : ~din;
   endtask : put
endmodule : dpr_port_drv

// *** verification/dpr_ram_tb_top.sv ***
// Purpose: Self-checking bench for dpr_ram.
// Assumes: Both ports 16 bits, window of two edges.
// Notes: Expected bus values queue up per edge.
`timescale 1ns/1ps
module dpr_ram_tb_top;
   typedef struct {int cyc; bit pb; logic [15:0] val;} dpr_exp_s;
   localparam logic [2:0] OFF = 3'b000, RD = 3'b100, WR = 3'b110, CLR = 3'b101;
   logic clk, rst_n, a_en, a_we, a_rst, b_en, b_we, b_rst;
   logic [7:0] a_addr, b_addr;
   logic [15:0] a_din, b_din, a_bus, b_bus, d0, d1;
   logic [15:0] dv [8];
   int seed = 32'haddb609c;
   int edge_n = 0, miscompares = 0, n_checks = 0;
   dpr_exp_s q[$];
   dpr_port_drv dpr_port_drv_inst_a (.en(a_en), .we(a_we), .out_rst(a_rst), .addr(a_addr),
      .din(a_din));
   dpr_port_drv dpr_port_drv_inst_b (.en(b_en), .we(b_we), .out_rst(b_rst), .addr(b_addr),
      .din(b_din));
   dpr_ram #(.A_WIDTH(16), .B_WIDTH(16), .CCS_WINDOW_CYC(2)) dpr_ram_inst (.clk(clk),
      .rst_n(rst_n), .port_a_en(a_en), .port_a_we(a_we), .port_a_out_rst(a_rst),
      .port_a_addr(a_addr), .port_a_write_data_in(a_din), .port_a_read_bus(a_bus),
      .port_b_en(b_en), .port_b_we(b_we), .port_b_out_rst(b_rst), .port_b_addr(b_addr),
      .port_b_write_data_in(b_din), .port_b_read_bus(b_bus));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) edge_n <= edge_n + 1;
   task automatic go(input logic [2:0] ca, input logic [7:0] aa, input logic [15:0] da,
      input logic [2:0] cb, input logic [7:0] ab, input logic [15:0] db);
      @(posedge clk);
      #1;
      dpr_port_drv_inst_a.put(ca, aa, da);
      dpr_port_drv_inst_b.put(cb, ab, db);
   endtask : go
   task automatic note_exp(input bit pb, input logic [15:0] v);
      q.push_back('{edge_n + 1, pb, v});
   endtask : note_exp
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic final_report;
      if (q.size() != 0) begin
         miscompares++;
         $display("CHECK FAILED pending_expectations expected 0 seen %0d", q.size());
      end
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   always @(posedge clk) begin
      #2;
      while (q.size() > 0 && q[0].cyc == edge_n) begin
         chk(q[0].pb ? "port_b_read_bus" : "port_a_read_bus", q[0].val, q[0].pb ? b_bus : a_bus);
         void'(q.pop_front());
      end
   end
   initial begin
      repeat (200) @(posedge clk);
      miscompares++;
      final_report();
   end
   initial begin
      rst_n = 1'b0;
      d0 = 16'($random(seed));
      d1 = 16'($random(seed));
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      go(WR, 8'h00, d0, RD, 8'h00, 16'h0000);
      note_exp(1'b0, d0);
      note_exp(1'b1, 'x);
      go(OFF, 8'h00, 16'h0000, OFF, 8'h00, 16'h0000);
      note_exp(1'b0, d0);
      go(OFF, 8'h00, 16'h0000, RD, 8'h00, 16'h0000);
      note_exp(1'b1, d0);
      go(WR, 8'h00, d1, OFF, 8'h00, 16'h0000);
      note_exp(1'b1, d0);
      go(OFF, 8'h00, 16'h0000, OFF, 8'h00, 16'h0000);
      go(OFF, 8'h00, 16'h0000, OFF, 8'h00, 16'h0000);
      go(OFF, 8'h00, 16'h0000, RD, 8'h00, 16'h0000);
      note_exp(1'b1, d1);
      go(WR, 8'h7E, d0, WR, 8'h7E, d1);
      note_exp(1'b1, d1);
      go(OFF, 8'h00, 16'h0000, OFF, 8'h00, 16'h0000);
      go(OFF, 8'h00, 16'h0000, OFF, 8'h00, 16'h0000);
      go(RD, 8'h7E, 16'h0000, OFF, 8'h00, 16'h0000);
      note_exp(1'b0, 'x);
      go(CLR, 8'h00, 16'h0000, WR, 8'h30, d0);
      note_exp(1'b0, 16'h0000);
      go(OFF, 8'h00, 16'h0000, RD, 8'h30, 16'h0000);
      note_exp(1'b1, d0);
      // Own write then own read of one word
      go(WR, 8'h40, d1, OFF, 8'h00, 16'h0000);
      note_exp(1'b0, d1);
      go(RD, 8'h40, 16'h0000, OFF, 8'h00, 16'h0000);
      note_exp(1'b0, d1);
      // Port B clear leaves the array alone
      go(OFF, 8'h00, 16'h0000, CLR, 8'h40, 16'h0000);
      note_exp(1'b1, 16'h0000);
      go(OFF, 8'h00, 16'h0000, RD, 8'h40, 16'h0000);
      note_exp(1'b1, d1);
      // Read one edge after the other port's write: inside a two-edge window
      go(WR, 8'h50, d0, OFF, 8'h00, 16'h0000);
      go(OFF, 8'h00, 16'h0000, RD, 8'h50, 16'h0000);
      note_exp(1'b1, 'x);
      go(OFF, 8'h00, 16'h0000, RD, 8'h50, 16'h0000);
      note_exp(1'b1, d0);
      // Write one edge after the other port's write leaves the word unknown
      go(WR, 8'h60, d0, OFF, 8'h00, 16'h0000);
      go(OFF, 8'h00, 16'h0000, WR, 8'h60, d1);
      note_exp(1'b1, d1);
      go(OFF, 8'h00, 16'h0000, OFF, 8'h00, 16'h0000);
      go(OFF, 8'h00, 16'h0000, RD, 8'h60, 16'h0000);
      note_exp(1'b1, 'x);
      for (int i = 0; i < 8; i++) begin
         dv[i] = 16'($random(seed));
         go(WR, 8'(8'h10 + i), dv[i], OFF, 8'h00, 16'h0000);
         note_exp(1'b0, dv[i]);
      end
      for (int i = 0; i < 8; i++) begin
         go(OFF, 8'h00, 16'h0000, RD, 8'(8'h10 + i), 16'h0000);
         note_exp(1'b1, dv[i]);
      end
      go(OFF, 8'h00, 16'h0000, OFF, 8'h00, 16'h0000);
      go(OFF, 8'h00, 16'h0000, OFF, 8'h00, 16'h0000);
      final_report();
   end
endmodule : dpr_ram_tb_top
bind dpr_ram dpr_ram_sva #(.A_WIDTH(A_WIDTH), .B_WIDTH(B_WIDTH),
   .CCS_WINDOW_CYC(CCS_WINDOW_CYC)) dpr_ram_sva_inst (.clk(clk), .rst_n(rst_n),
   .port_a_en(port_a_en), .port_a_we(port_a_we), .port_a_out_rst(port_a_out_rst),
   .port_a_addr(port_a_addr), .port_a_write_data_in(port_a_write_data_in),
   .port_a_read_bus(port_a_read_bus), .port_b_en(port_b_en), .port_b_we(port_b_we),
   .port_b_out_rst(port_b_out_rst), .port_b_addr(port_b_addr),
   .port_b_write_data_in(port_b_write_data_in), .port_b_read_bus(port_b_read_bus));
